/* File: pkg/ppc_pkg.sv */
`default_nettype none
package ppc_pkg;
  localparam int CLK_HZ = 40000000;
  // time figures in their own units
  localparam int BACKOFF_MS = 400;
  localparam int DEGLITCH_MIN_NS = 1000;
  localparam int DEGLITCH_MAX_NS = 5000;
  localparam int BACKOFF_CYC = (CLK_HZ / 1000) * BACKOFF_MS;
  localparam int DEGLITCH_CYC = (DEGLITCH_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000 + 4;
  localparam int OVLD_TICKS = 2400;
  localparam int START_TICKS = 2400;
  localparam int DOWN_DIV = 16;
  localparam int NPORT = 8;
  localparam logic [3:0] ADDR_RST = 4'hf;

  typedef enum logic [2:0] {
    PPC_OFF = 3'h0,
    PPC_BACKOFF = 3'h1,
    PPC_DETECT = 3'h2,
    PPC_START = 3'h3,
    PPC_ON = 3'h4,
    PPC_FAULT = 3'h5
  } ppc_state_t;

  typedef struct packed {
    logic detectActive;
    logic probeHigh;
    logic dischargeOn;
    logic senseResOn;
    logic gateOn;
  } ppc_port_out_t;

  typedef struct packed {
    logic portHot;
    logic overCut;
    logic detectOk;
  } ppc_port_in_t;
endpackage
`default_nettype wire

/* File: src/ppc_deglitch.sv */
`timescale 1ns/100ps
`default_nettype none
module ppc_deglitch #(
  parameter int CYC = 44,
  parameter logic INIT = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic pinIn,
  output logic level
);
  if (CYC < 2 || CYC > 65535) begin : gBadCyc
    $error("deglitch count out of range");
  end
  logic sync1_r;
  logic sync2_r;
  logic [15:0] cnt_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= INIT;
      sync2_r <= INIT;
    end else if (clkEn) begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 16'h0000;
      level <= INIT;
    end else if (clkEn) begin
      if (sync2_r == level) begin
        cnt_r <= 16'h0000;
      end else if (cnt_r == 16'(CYC - 1)) begin
        cnt_r <= 16'h0000;
        level <= sync2_r;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/ppc_fault_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module ppc_fault_timer #(
  parameter int W = 16,
  parameter int DIV = 16
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic tick,
  input wire logic overCut,
  input wire logic starting,
  input wire logic clear,
  input wire logic [W-1:0] ovldLim,
  input wire logic [W-1:0] startLim,
  output logic expired,
  output logic atZero
);
  if (DIV < 2 || DIV > 256) begin : gBadDiv
    $error("down divider out of range");
  end
  logic [W-1:0] count_r;
  logic [7:0] div_r;
  logic [W-1:0] limit;
  assign limit = starting ? startLim : ovldLim;
  assign atZero = (count_r == '0);
  assign expired = (count_r >= limit);
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= '0;
      div_r <= 8'h00;
    end else if (clkEn) begin
      if (clear) begin
        count_r <= '0;
        div_r <= 8'h00;
      end else if (tick && overCut) begin
        if (!expired) count_r <= count_r + 1'b1;
        div_r <= 8'h00;
      end else if (tick && !atZero) begin
        if (div_r == 8'(DIV - 1)) begin
          div_r <= 8'h00;
          count_r <= count_r - 1'b1;
        end else begin
          div_r <= div_r + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/ppc_port_protect.sv */
// What this block does
// - semiauto: port above 2.5 V gets discharge and 400 ms detect backoff
// - detection sinks two probe levels, four points, before powering
// - sense resistor connected except during detection or while port is on
// - gate driven on through low-current source at port turn on
// - gate pulled low on supply low, overcurrent timeout or manual shutdown
// - powered port above cut threshold runs an up-counting fault timer
// - timer at overload time, or startup time at turn on, shuts port
// - below threshold timer counts down at 1/16 rate; re-enable only at zero
// - interrupt pin pulled low open-drain while any interrupt bit set
// - fast shutdown active high, deglitched 1 to 5 us
// - accepted fast shutdown turns off ports chosen by priority mask
// - deglitched low reset turns off all ports and restores power-up state
// - internal power-on reset acts independent of the reset pin
// - separate serial data in and open-drain serial data out
// - four pulled-up address select pins set the slave address
`timescale 1ns/100ps
`default_nettype none
module ppc_port_protect #(
  parameter int NP = ppc_pkg::NPORT,
  parameter int TW = 16,
  parameter int BACKOFF = ppc_pkg::BACKOFF_CYC,
  parameter int TICK_DIV = 40
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic semiAuto,
  input wire logic [NP-1:0] portEnable,
  input wire logic [NP-1:0] manualOff,
  input wire logic [NP-1:0] priorityMask,
  input wire logic supplyOk,
  input wire logic [NP-1:0] portHot,
  input wire logic [NP-1:0] overCut,
  input wire logic [NP-1:0] detectOk,
  input wire logic fast_shutdown_in,
  input wire logic resetPinN,
  input wire logic [NP-1:0] intBits,
  input wire logic serial_data_in,
  input wire logic serialDataDrive,
  input wire logic [3:0] addr_select_pins,
  output logic [NP-1:0] port_gate_drive,
  output logic [NP-1:0] dischargeOn,
  output logic [NP-1:0] senseResOn,
  output logic [NP-1:0] probeHigh,
  output logic [NP-1:0] detectActive,
  output logic [NP-1:0] portOn,
  output logic [NP-1:0] faultLatched,
  output logic intOut,
  output logic intOe,
  output logic serialDataIn,
  output logic serial_data_out,
  output logic serialDataOe,
  output logic [3:0] slaveAddr,
  output logic fastShutdown,
  output logic devReset
);
  // ***********************************
  // parameter checks
  // ***********************************
  if (NP < 1 || NP > 32) begin : gBadPorts
    $error("port count out of range");
  end
  if (TW < 12 || TW > 32) begin : gBadWidth
    $error("fault timer width cannot hold the fault limits");
  end
  if (BACKOFF < 2) begin : gBadBackoff
    $error("backoff count too short");
  end
  if (TICK_DIV < 1 || TICK_DIV > 65536) begin : gBadTick
    $error("tick divider out of range");
  end

  // ***********************************
  // input conditioning and resets
  // ***********************************
  logic rstLevel;
  logic porDone_r;
  logic sdi1_r;
  logic [3:0] adr1_r;
  logic [3:0] adr2_r;
  logic [NP-1:0] hot1_r;
  logic [NP-1:0] hot2_r;
  logic [NP-1:0] cut1_r;
  logic [NP-1:0] cut2_r;
  logic [NP-1:0] det1_r;
  logic [NP-1:0] det2_r;
  logic sup1_r;
  logic sup2_r;

  ppc_deglitch #(.CYC(ppc_pkg::DEGLITCH_CYC), .INIT(1'b0)) uFss (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(fast_shutdown_in),
    .level(fastShutdown)
  );
  ppc_deglitch #(.CYC(ppc_pkg::DEGLITCH_CYC), .INIT(1'b1)) uRst (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinIn(resetPinN),
    .level(rstLevel)
  );

  // internal power-on reset, independent of the pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) porDone_r <= 1'b0;
    else if (clkEn) porDone_r <= 1'b1;
  end
  assign devReset = !rstLevel || !porDone_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sdi1_r <= 1'b1;
      serialDataIn <= 1'b1;
    end else if (clkEn) begin
      sdi1_r <= serial_data_in;
      serialDataIn <= sdi1_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      adr1_r <= ppc_pkg::ADDR_RST;
      adr2_r <= ppc_pkg::ADDR_RST;
      slaveAddr <= ppc_pkg::ADDR_RST;
    end else if (clkEn) begin
      adr1_r <= addr_select_pins;
      adr2_r <= adr1_r;
      slaveAddr <= adr2_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hot1_r <= '0;
      hot2_r <= '0;
      cut1_r <= '0;
      cut2_r <= '0;
      det1_r <= '0;
      det2_r <= '0;
    end else if (clkEn) begin
      hot1_r <= portHot;
      hot2_r <= hot1_r;
      cut1_r <= overCut;
      cut2_r <= cut1_r;
      det1_r <= detectOk;
      det2_r <= det1_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sup1_r <= 1'b0;
      sup2_r <= 1'b0;
    end else if (clkEn) begin
      sup1_r <= supplyOk;
      sup2_r <= sup1_r;
    end
  end

  // ***********************************
  // open-drain outputs
  // ***********************************
  assign serial_data_out = 1'b0;
  assign serialDataOe = serialDataDrive;
  assign intOut = 1'b0;
  assign intOe = |intBits;

  // ***********************************
  // timer tick
  // ***********************************
  logic [15:0] tickCnt_r;
  logic tick;
  assign tick = (tickCnt_r == 16'(TICK_DIV - 1));
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tickCnt_r <= 16'h0000;
    else if (clkEn) tickCnt_r <= tick ? 16'h0000 : tickCnt_r + 16'h0001;
  end

  // ***********************************
  // per-port control
  // ***********************************
  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : gPort
      ppc_pkg::ppc_state_t state_r;
      logic [31:0] bo_r;
      logic [1:0] pt_r;
      logic expired;
      logic atZero;
      logic starting;
      logic kill;
      ppc_pkg::ppc_port_out_t o;

      assign starting = (state_r == ppc_pkg::PPC_START);
      // a port leaves power on any of these; reset and supply low act on all ports
      assign kill = devReset || !sup2_r || manualOff[p]
        || (fastShutdown && priorityMask[p]) || !portEnable[p];

      ppc_fault_timer #(.W(TW), .DIV(ppc_pkg::DOWN_DIV)) uTmr (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .tick(tick),
        .overCut(cut2_r[p] && (state_r == ppc_pkg::PPC_ON || starting)),
        .starting(starting),
        .clear(devReset),
        .ovldLim(TW'(ppc_pkg::OVLD_TICKS)),
        .startLim(TW'(ppc_pkg::START_TICKS)),
        .expired(expired),
        .atZero(atZero)
      );

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          state_r <= ppc_pkg::PPC_OFF;
          bo_r <= 32'h0000_0000;
          pt_r <= 2'h0;
        end else if (clkEn) begin
          case (state_r)
            ppc_pkg::PPC_OFF: begin
              if (!kill && atZero) begin
                if (semiAuto && hot2_r[p]) begin
                  bo_r <= 32'h0000_0000;
                  state_r <= ppc_pkg::PPC_BACKOFF;
                end else begin
                  pt_r <= 2'h0;
                  state_r <= ppc_pkg::PPC_DETECT;
                end
              end
            end
            ppc_pkg::PPC_BACKOFF: begin
              if (kill) state_r <= ppc_pkg::PPC_OFF;
              else if (bo_r == 32'(BACKOFF - 1)) begin
                pt_r <= 2'h0;
                state_r <= ppc_pkg::PPC_DETECT;
              end else bo_r <= bo_r + 32'h0000_0001;
            end
            ppc_pkg::PPC_DETECT: begin
              if (kill) state_r <= ppc_pkg::PPC_OFF;
              else if (tick) begin
                pt_r <= pt_r + 2'h1;
                if (pt_r == 2'h3) state_r <= det2_r[p] ? ppc_pkg::PPC_START
                                                       : ppc_pkg::PPC_OFF;
              end
            end
            ppc_pkg::PPC_START, ppc_pkg::PPC_ON: begin
              if (kill) state_r <= ppc_pkg::PPC_OFF;
              else if (expired) state_r <= ppc_pkg::PPC_FAULT;
              else if (starting && !cut2_r[p]) state_r <= ppc_pkg::PPC_ON;
            end
            ppc_pkg::PPC_FAULT: begin
              if (devReset || atZero) state_r <= ppc_pkg::PPC_OFF;
            end
            default: state_r <= ppc_pkg::PPC_OFF;
          endcase
        end
      end

      always_comb begin
        o.detectActive = (state_r == ppc_pkg::PPC_DETECT);
        o.probeHigh = o.detectActive && pt_r[1];
        o.dischargeOn = (state_r == ppc_pkg::PPC_BACKOFF);
        o.gateOn = (state_r == ppc_pkg::PPC_START || state_r == ppc_pkg::PPC_ON);
        o.senseResOn = !o.detectActive && !o.gateOn;
      end

      ppc_pkg::ppc_port_out_t out_r;
      logic onOut_r;
      logic faultOut_r;

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          out_r <= '{detectActive: 1'b0, probeHigh: 1'b0, dischargeOn: 1'b0,
                     senseResOn: 1'b1, gateOn: 1'b0};
        end else if (clkEn) begin
          out_r.detectActive <= o.detectActive;
          out_r.probeHigh <= o.probeHigh;
          out_r.dischargeOn <= o.dischargeOn;
          out_r.senseResOn <= o.senseResOn;
          out_r.gateOn <= o.gateOn && !kill;
        end
      end

      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          onOut_r <= 1'b0;
          faultOut_r <= 1'b0;
        end else if (clkEn) begin
          onOut_r <= (state_r == ppc_pkg::PPC_ON);
          faultOut_r <= (state_r == ppc_pkg::PPC_FAULT);
        end
      end

      assign port_gate_drive[p] = out_r.gateOn;
      assign dischargeOn[p] = out_r.dischargeOn;
      assign senseResOn[p] = out_r.senseResOn;
      assign probeHigh[p] = out_r.probeHigh;
      assign detectActive[p] = out_r.detectActive;
      assign portOn[p] = onOut_r;
      assign faultLatched[p] = faultOut_r;
    end
  endgenerate
endmodule
`default_nettype wire

/* File: sim/ppc_port_protect_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module ppc_port_protect_sva (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic supplyOk,
  input wire logic [7:0] manualOff,
  input wire logic [7:0] priorityMask,
  input wire logic fast_shutdown_in,
  input wire logic [7:0] intBits,
  input wire logic serialDataDrive,
  input wire logic [7:0] port_gate_drive,
  input wire logic [7:0] dischargeOn,
  input wire logic [7:0] senseResOn,
  input wire logic [7:0] detectActive,
  input wire logic [7:0] portOn,
  input wire logic [7:0] faultLatched,
  input wire logic intOut,
  input wire logic intOe,
  input wire logic serial_data_out,
  input wire logic serialDataOe,
  input wire logic fastShutdown
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  int_drive_a: assert property (intOe == |intBits)
    else $error("interrupt enable wrong");
  int_level_a: assert property (intOe |-> !intOut)
    else $error("interrupt level wrong");
  sda_drive_a: assert property (
    serialDataOe == serialDataDrive && !serial_data_out)
    else $error("serial data drive wrong");
  sense_res_a: assert property (
    ((detectActive | portOn) & senseResOn) == 8'h00)
    else $error("sense resistor on while busy");
  discharge_a: assert property (
    (dischargeOn & (port_gate_drive | detectActive)) == 8'h00)
    else $error("discharge during detect or power");
  supply_kill_a: assert property (
    !supplyOk [*5] |-> port_gate_drive == 8'h00)
    else $error("gate on with supply low");
  manual_kill_a: assert property (
    manualOff[1] [*5] |-> !port_gate_drive[1])
    else $error("gate on with manual off");
  fast_kill_a: assert property (
    fastShutdown [*3] |-> (port_gate_drive & priorityMask) == 8'h00)
    else $error("priority port on in fast shutdown");
  fault_hold_a: assert property (
    (faultLatched & $past(faultLatched) & port_gate_drive) == 8'h00)
    else $error("gate on while faulted");
  deglitch_a: assert property (
    $rose(fastShutdown) |-> $past(fast_shutdown_in, 40))
    else $error("fast shutdown not deglitched");
  cover property ($rose(faultLatched[1]));
  cover property ($fell(port_gate_drive[0]) && fastShutdown);
  cover property ($rose(port_gate_drive[0]));
endmodule
bind ppc_port_protect ppc_port_protect_sva u_sva (
  .sys_clk(sys_clk),
  .rstn(rstn),
  .supplyOk(supplyOk),
  .manualOff(manualOff),
  .priorityMask(priorityMask),
  .fast_shutdown_in(fast_shutdown_in),
  .intBits(intBits),
  .serialDataDrive(serialDataDrive),
  .port_gate_drive(port_gate_drive),
  .dischargeOn(dischargeOn),
  .senseResOn(senseResOn),
  .detectActive(detectActive),
  .portOn(portOn),
  .faultLatched(faultLatched),
  .intOut(intOut),
  .intOe(intOe),
  .serial_data_out(serial_data_out),
  .serialDataOe(serialDataOe),
  .fastShutdown(fastShutdown)
);
`default_nettype wire

/* File: sim/ppc_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ppc_host_model (
  input wire logic intOut,
  input wire logic intOe,
  input wire logic serial_data_out,
  input wire logic serialDataOe,
  output logic intWire,
  output logic sdaWire
);
  // open-drain lines with host pull-ups
  assign intWire = intOe ? intOut : 1'b1;
  assign sdaWire = serialDataOe ? serial_data_out : 1'b1;
endmodule
`default_nettype wire

/* File: sim/tb_ppc_port_protect.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_ppc_port_protect;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clkEn = 1'b1;
  logic semiAuto = 1'b1;
  logic supplyOk = 1'b1, fast_shutdown_in = 1'b0, resetPinN = 1'b1, serialDataDrive = 1'b0;
  logic [7:0] portEnable = 8'hff, manualOff = 8'h00, priorityMask = 8'h01, portHot = 8'h00;
  logic [7:0] overCut = 8'h00, detectOk = 8'h00, intBits = 8'h00;
  logic [3:0] addr_select_pins = 4'ha;
  logic [7:0] port_gate_drive, dischargeOn, senseResOn, probeHigh, detectActive, portOn;
  logic [7:0] faultLatched;
  logic intOut, intOe, serialDataIn, serial_data_out, serialDataOe, fastShutdown, devReset;
  logic intWire, sdaWire, serial_data_in, seenProbe;
  logic [3:0] slaveAddr;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  assign serial_data_in = sdaWire;
  always #12.5 sys_clk = ~sys_clk;
  ppc_port_protect #(.BACKOFF(200), .TICK_DIV(2)) uut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .semiAuto(semiAuto),
    .portEnable(portEnable),
    .manualOff(manualOff),
    .priorityMask(priorityMask),
    .supplyOk(supplyOk),
    .portHot(portHot),
    .overCut(overCut),
    .detectOk(detectOk),
    .fast_shutdown_in(fast_shutdown_in),
    .resetPinN(resetPinN),
    .intBits(intBits),
    .serial_data_in(serial_data_in),
    .serialDataDrive(serialDataDrive),
    .addr_select_pins(addr_select_pins),
    .port_gate_drive(port_gate_drive),
    .dischargeOn(dischargeOn),
    .senseResOn(senseResOn),
    .probeHigh(probeHigh),
    .detectActive(detectActive),
    .portOn(portOn),
    .faultLatched(faultLatched),
    .intOut(intOut),
    .intOe(intOe),
    .serialDataIn(serialDataIn),
    .serial_data_out(serial_data_out),
    .serialDataOe(serialDataOe),
    .slaveAddr(slaveAddr),
    .fastShutdown(fastShutdown),
    .devReset(devReset)
  );
  ppc_host_model host (
    .intOut(intOut),
    .intOe(intOe),
    .serial_data_out(serial_data_out),
    .serialDataOe(serialDataOe),
    .intWire(intWire),
    .sdaWire(sdaWire)
  );
  // ******************************
  // helpers
  // ******************************
  task print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wait_gate(input logic [7:0] exp);
    n = 0;
    while ((port_gate_drive & 8'h03) !== exp && n < 2000) begin
      @(negedge sys_clk);
      if (probeHigh[0] === 1'b1) seenProbe = 1'b1;
      n++;
    end
    chk("gate", exp, port_gate_drive & 8'h03);
  endtask
  task idle(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // ******************************
  // scenarios
  // ******************************
  task t_int;
    for (int i = 0; i < 9; i++) begin
      intBits = (i == 8) ? 8'h00 : 8'h01 << i;
      #1 chk("intWire", {7'h0, intBits == 8'h00}, {7'h0, intWire});
      @(negedge sys_clk);
    end
    serialDataDrive = 1'b1;
    idle(4);
    chk("sdaIn", 8'h00, {7'h0, serialDataIn});
    serialDataDrive = 1'b0;
    idle(4);
    chk("sdaIn", 8'h01, {7'h0, serialDataIn});
    chk("addr", 8'h0a, {4'h0, slaveAddr});
    $display("done int");
  endtask
  task t_power;
    portHot = 8'h03;
    idle(20);
    chk("discharge", 8'h03, dischargeOn & 8'h03);
    portHot = 8'h00;
    detectOk = 8'h03;
    seenProbe = 1'b0;
    wait_gate(8'h03);
    chk("probe", 8'h01, {7'h0, seenProbe});
    chk("others", 8'h00, port_gate_drive & 8'hfc);
    $display("done power");
  endtask
  task t_fast;
    fast_shutdown_in = 1'b1;
    idle(10);
    fast_shutdown_in = 1'b0;
    idle(60);
    chk("glitch", 8'h03, port_gate_drive & 8'h03);
    fast_shutdown_in = 1'b1;
    idle(60);
    chk("shed", 8'h02, port_gate_drive & 8'h03);
    fast_shutdown_in = 1'b0;
    wait_gate(8'h03);
    $display("done fast");
  endtask
  task t_kill;
    manualOff = 8'h02;
    idle(8);
    chk("manual", 8'h01, port_gate_drive & 8'h03);
    manualOff = 8'h00;
    wait_gate(8'h03);
    supplyOk = 1'b0;
    idle(8);
    chk("supply", 8'h00, port_gate_drive);
    supplyOk = 1'b1;
    wait_gate(8'h03);
    $display("done kill");
  endtask
  task t_overload;
    overCut = 8'h02;
    n = 0;
    while (port_gate_drive[1] === 1'b1 && n < 6000) begin
      @(negedge sys_clk);
      n++;
    end
    // 2400 ticks of 2 cycles each
    chk("early", 8'h01, {7'h0, n > 4700 && n < 4900});
    chk("fault", 8'h02, faultLatched & 8'h03);
    overCut = 8'h00;
    idle(2000);
    chk("held", 8'h01, port_gate_drive & 8'h03);
    $display("done overload");
  endtask
  task t_reset_pin;
    resetPinN = 1'b0;
    idle(10);
    resetPinN = 1'b1;
    idle(60);
    chk("rstGlitch", 8'h01, port_gate_drive & 8'h01);
    resetPinN = 1'b0;
    idle(60);
    chk("rstGate", 8'h00, port_gate_drive);
    chk("devReset", 8'h01, {7'h0, devReset});
    portEnable = 8'h00;
    resetPinN = 1'b1;
    // host holds off power requests after reset
    idle(60);
    portEnable = 8'hff;
    wait_gate(8'h03);
    $display("done reset pin");
  endtask
  initial begin
    idle(2);
    chk("rstSense", 8'hff, senseResOn);
    chk("rstGate", 8'h00, port_gate_drive);
    rstn = 1'b1;
    idle(2);
    t_int();
    t_power();
    t_fast();
    t_kill();
    t_overload();
    t_reset_pin();
    print_verdict();
  end
endmodule
`default_nettype wire
